// ===== pkg/ars_map.svh
// Register offsets, field positions, reset values and timing counts
// for the sector read command block. Included by its bare name.
`ifndef ARS_MAP_SVH
`define ARS_MAP_SVH

// Register byte offsets on the AXI4-Lite slave
`define ARS_OFF_DATA      12'h000
`define ARS_OFF_FEATURE   12'h004
`define ARS_OFF_ERROR     12'h008
`define ARS_OFF_COUNT     12'h00C
`define ARS_OFF_ADDR_LO   12'h010
`define ARS_OFF_ADDR_MID  12'h014
`define ARS_OFF_ADDR_HI   12'h018
`define ARS_OFF_TARGET    12'h01C
`define ARS_OFF_OPCODE    12'h020
`define ARS_OFF_STATUS    12'h024
`define ARS_OFF_DEVCTL    12'h028
`define ARS_OFF_IRQ_STAT  12'h02C
`define ARS_OFF_IRQ_MASK  12'h030
`define ARS_OFF_INJECT    12'h034

// Opcodes
`define ARS_OP_READ28     8'h20
`define ARS_OP_READ48     8'h24

// Target register fields
`define ARS_TGT_LINEAR    6
// Device control field
`define ARS_CTL_HOB       7

// Status bits
`define ARS_ST_BSY        7
`define ARS_ST_RDY        6
`define ARS_ST_DSC        4
`define ARS_ST_DRQ        3
`define ARS_ST_ERR        0
// Error bits
`define ARS_ER_UNC        6
`define ARS_ER_IDN        4
`define ARS_ER_ABT        2

// Interrupt status bits
`define ARS_IRQ_DONE      0
`define ARS_IRQ_FAIL      1

// Sector geometry, media fetch timing and reset status
`define ARS_WORDS_PER_SEC 9'h100
`define ARS_FETCH_CYC     8'h04
`define ARS_RESET_STATUS  8'h50

`endif

// ===== pkg/ars_pkg.sv
// Types for the sector read command block.
// Constants live in ars_map.svh.
package ars_pkg;
   // Command sequencer states
   typedef enum logic [2:0]
   {
      ARS_IDLE,
      ARS_FETCH,
      ARS_XFER,
      ARS_DONE
   } ars_state_t;
endpackage

// ===== verilog/ars_read_cmd.sv
// Sector read command interpreter with AXI4-Lite register slave.
// Assumes a media source that returns 16-bit words with a valid strobe,
// and a fault injection register standing in for media error reports.
`timescale 1ns/10ps
`include "ars_map.svh"

module ars_read_cmd
#(
   parameter int WORDS = 256             // Words per sector
)
(
   // Clock and reset
   input  wire logic        CORE_CLK,
   input  wire logic        RST_N,
   // AXI4-Lite write address
   input  wire logic [11:0] AWADDR,
   input  wire logic        AWVALID,
   output logic             AWREADY,
   // AXI4-Lite write data
   input  wire logic [31:0] WDATA,
   input  wire logic [3:0]  WSTRB,
   input  wire logic        WVALID,
   output logic             WREADY,
   // AXI4-Lite write response
   output logic [1:0]       BRESP,
   output logic             BVALID,
   input  wire logic        BREADY,
   // AXI4-Lite read address
   input  wire logic [11:0] ARADDR,
   input  wire logic        ARVALID,
   output logic             ARREADY,
   // AXI4-Lite read data
   output logic [31:0]      RDATA,
   output logic [1:0]       RRESP,
   output logic             RVALID,
   input  wire logic        RREADY,
   // Media word source
   output logic             MEDIA_REQ,
   output logic [47:0]      MEDIA_ADDR,
   input  wire logic [15:0] MEDIA_WORD,
   input  wire logic        MEDIA_VALID,
   // Interrupt
   output logic             IRQ
);

   ////////////////////////////////////////////////////////////////////
   // Register file state
   logic [7:0]  feat_reg;                 // Command parameter, unused
   logic [7:0]  cnt_reg, cnt_prev_reg;    // Count, current and previous
   logic [7:0]  lo_reg, lo_prev_reg;      // Address low byte pair
   logic [7:0]  mid_reg, mid_prev_reg;    // Address mid byte pair
   logic [7:0]  hi_reg, hi_prev_reg;      // Address high byte pair
   logic [7:0]  tgt_reg;                  // Target and address top
   logic [7:0]  err_reg;                  // Fault detail
   logic [7:0]  stat_reg;                 // Completion flags
   logic        hob_reg;                  // High order byte readback
   logic [1:0]  irq_stat_reg;             // Sticky events
   logic [1:0]  irq_mask_reg;             // Event enables
   logic [31:0] inject_reg;               // Fault sector, bit 31 arms
   logic [15:0] word_reg;                 // Transfer word
   logic        word_full_reg;            // Word waits for host

   // Command state
   ars_pkg::ars_state_t state_reg;
   logic        ext_reg;                  // 48-bit command active
   logic [16:0] left_reg;                 // Sectors still to send
   logic [47:0] cur_reg;                  // Current sector address
   logic [31:0] done_reg;                 // Sectors already sent
   logic [8:0]  wcnt_reg;                 // Words sent this sector
   logic [7:0]  fcnt_reg;                 // Fetch wait counter

   // Bus channel state
   logic        aw_got_reg, w_got_reg;
   logic [11:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;

   ////////////////////////////////////////////////////////////////////
   // Write decode
   wire        wr_go   = aw_got_reg && w_got_reg && !BVALID;
   wire        wr_b0   = wr_go && w_strb_reg[0];
   wire [7:0]  wb      = w_data_reg[7:0];
   wire        wr_feat = wr_b0 && aw_addr_reg == `ARS_OFF_FEATURE;
   wire        wr_cnt  = wr_b0 && aw_addr_reg == `ARS_OFF_COUNT;
   wire        wr_lo   = wr_b0 && aw_addr_reg == `ARS_OFF_ADDR_LO;
   wire        wr_mid  = wr_b0 && aw_addr_reg == `ARS_OFF_ADDR_MID;
   wire        wr_hi   = wr_b0 && aw_addr_reg == `ARS_OFF_ADDR_HI;
   wire        wr_tgt  = wr_b0 && aw_addr_reg == `ARS_OFF_TARGET;
   wire        wr_ctl  = wr_b0 && aw_addr_reg == `ARS_OFF_DEVCTL;
   wire        wr_msk  = wr_b0 && aw_addr_reg == `ARS_OFF_IRQ_MASK;
   wire        wr_ist  = wr_b0 && aw_addr_reg == `ARS_OFF_IRQ_STAT;
   wire        wr_inj  = wr_go && aw_addr_reg == `ARS_OFF_INJECT
                         && w_strb_reg == 4'hF;
   wire        wr_op   = wr_b0 && aw_addr_reg == `ARS_OFF_OPCODE
                         && state_reg == ars_pkg::ARS_IDLE;
   wire        wr_map  = aw_addr_reg <= `ARS_OFF_INJECT
                         && aw_addr_reg[1:0] == 2'h0;

   // Opcode recognition, bit 0 masked for the 28-bit read
   wire        op28    = wr_op && wb[7:1] == `ARS_OP_READ28 >> 1;
   wire        op48    = wr_op && wb == `ARS_OP_READ48;
   wire        op_bad  = wr_op && !op28 && !op48;

   // Start count: zero selects the largest transfer
   wire [16:0] n28     = (cnt_reg == 8'h00) ? 17'h00100
                         : {9'h000, cnt_reg};
   wire [15:0] c48     = {cnt_prev_reg, cnt_reg};
   wire [16:0] n48     = (c48 == 16'h0000) ? 17'h10000
                         : {1'b0, c48};

   // Start address: geometric and linear both pack the same fields
   wire [47:0] a28     = {20'h00000, tgt_reg[3:0], hi_reg, mid_reg,
                          lo_reg};
   wire [47:0] a48     = {hi_prev_reg, mid_prev_reg, lo_prev_reg,
                          hi_reg, mid_reg, lo_reg};

   // Data register read pops one word
   wire        rd_go   = ARVALID && ARREADY;
   wire        pop     = rd_go && ARADDR == `ARS_OFF_DATA;
   wire        last_w  = wcnt_reg == 9'(WORDS - 1);
   wire        take    = state_reg == ars_pkg::ARS_XFER && MEDIA_VALID
                         && !word_full_reg;
   wire        fail    = inject_reg[31]
                         && inject_reg[30:0] == done_reg[30:0];
   wire        sec_end = take && last_w;
   wire        finish  = sec_end && left_reg == 17'h00001;

   ////////////////////////////////////////////////////////////////////
   // Read multiplexer
   function automatic logic [7:0] hob_sel(input logic [7:0] cur,
                                           input logic [7:0] prev);
      hob_sel = hob_reg ? prev : cur;
   endfunction

   logic [31:0] rmux;
   always_comb
   begin
      unique case (ARADDR)
         `ARS_OFF_DATA:     rmux = {16'h0000, word_reg};
         `ARS_OFF_ERROR:    rmux = {24'h0, err_reg};
         `ARS_OFF_COUNT:    rmux = {24'h0, hob_sel(cnt_reg, cnt_prev_reg)};
         `ARS_OFF_ADDR_LO:  rmux = {24'h0, hob_sel(lo_reg, lo_prev_reg)};
         `ARS_OFF_ADDR_MID: rmux = {24'h0, hob_sel(mid_reg, mid_prev_reg)};
         `ARS_OFF_ADDR_HI:  rmux = {24'h0, hob_sel(hi_reg, hi_prev_reg)};
         `ARS_OFF_TARGET:   rmux = {24'h0, tgt_reg};
         `ARS_OFF_STATUS:   rmux = {24'h0, stat_reg};
         `ARS_OFF_DEVCTL:   rmux = {24'h0, hob_reg, 7'h00};
         `ARS_OFF_IRQ_STAT: rmux = {30'h0, irq_stat_reg};
         `ARS_OFF_IRQ_MASK: rmux = {30'h0, irq_mask_reg};
         `ARS_OFF_INJECT:   rmux = inject_reg;
         default:           rmux = 32'h0000_0000;
      endcase
   end
   wire rd_map = ARADDR <= `ARS_OFF_INJECT && ARADDR[1:0] == 2'h0
                 && ARADDR != `ARS_OFF_FEATURE
                 && ARADDR != `ARS_OFF_OPCODE;

   ////////////////////////////////////////////////////////////////////
   // Write address and data capture, either order
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         aw_got_reg  <= 1'b0;
         w_got_reg   <= 1'b0;
         aw_addr_reg <= 12'h000;
         w_data_reg  <= 32'h0;
         w_strb_reg  <= 4'h0;
      end
      else
      begin
         if (AWVALID && AWREADY)
         begin
            aw_got_reg  <= 1'b1;
            aw_addr_reg <= AWADDR;
         end
         else if (wr_go)
            aw_got_reg <= 1'b0;
         if (WVALID && WREADY)
         begin
            w_got_reg  <= 1'b1;
            w_data_reg <= WDATA;
            w_strb_reg <= WSTRB;
         end
         else if (wr_go)
            w_got_reg <= 1'b0;
      end
   end

   // Ready while the holding slot is empty
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         AWREADY <= 1'b0;
         WREADY  <= 1'b0;
         ARREADY <= 1'b0;
      end
      else
      begin
         AWREADY <= !aw_got_reg && !(AWVALID && AWREADY) && !BVALID;
         WREADY  <= !w_got_reg && !(WVALID && WREADY) && !BVALID;
         ARREADY <= !RVALID && !rd_go;
      end
   end

   // Write response, SLVERR for unmapped offsets
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         BVALID <= 1'b0;
         BRESP  <= 2'b00;
      end
      else if (wr_go)
      begin
         BVALID <= 1'b1;
         BRESP  <= wr_map ? 2'b00 : 2'b10;
      end
      else if (BREADY)
         BVALID <= 1'b0;
   end

   // Read response
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         RVALID <= 1'b0;
         RDATA  <= 32'h0;
         RRESP  <= 2'b00;
      end
      else if (rd_go)
      begin
         RVALID <= 1'b1;
         RDATA  <= rmux;
         RRESP  <= rd_map ? 2'b00 : 2'b10;
      end
      else if (RREADY)
         RVALID <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////
   // Host-written task file; earlier byte moves to previous
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         feat_reg <= 8'h00;
         {cnt_reg, cnt_prev_reg} <= 16'h0;
         {lo_reg, lo_prev_reg}   <= 16'h0;
         {mid_reg, mid_prev_reg} <= 16'h0;
         {hi_reg, hi_prev_reg}   <= 16'h0;
         tgt_reg  <= 8'h00;
         hob_reg  <= 1'b0;
         irq_mask_reg <= 2'b00;
         inject_reg   <= 32'h0;
      end
      else
      begin
         if (wr_feat) feat_reg <= wb;
         if (wr_ctl)  hob_reg  <= wb[`ARS_CTL_HOB];
         if (wr_msk)  irq_mask_reg <= wb[1:0];
         if (wr_inj)  inject_reg <= w_data_reg;
         if (wr_tgt)  tgt_reg <= wb;
         // Previous takes the older byte, so high goes first
         if (wr_cnt)
            {cnt_prev_reg, cnt_reg} <= {cnt_reg, wb};
         else if (state_reg != ars_pkg::ARS_IDLE && finish)
            {cnt_prev_reg, cnt_reg} <= 16'h0;
         else if (state_reg == ars_pkg::ARS_XFER && take && fail)
            {cnt_prev_reg, cnt_reg} <= left_reg[15:0];
         if (wr_lo)  {lo_prev_reg, lo_reg}   <= {lo_reg, wb};
         if (wr_mid) {mid_prev_reg, mid_reg} <= {mid_reg, wb};
         if (wr_hi)  {hi_prev_reg, hi_reg}   <= {hi_reg, wb};
         // Ending address: last sent sector, or failing one
         if (state_reg == ars_pkg::ARS_XFER && (finish || (take && fail)))
         begin
            if (!ext_reg && !(take && fail))
            begin
               lo_reg  <= cur_reg[7:0];
               mid_reg <= cur_reg[15:8];
               hi_reg  <= cur_reg[23:16];
               tgt_reg <= {tgt_reg[7:4], cur_reg[27:24]};
            end
            else
            begin
               {hi_prev_reg, mid_prev_reg, lo_prev_reg} <= cur_reg[47:24];
               {hi_reg, mid_reg, lo_reg} <= cur_reg[23:0];
               if (!ext_reg)
                  tgt_reg <= {tgt_reg[7:4], cur_reg[27:24]};
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Command sequencer: fetch a sector, then hand words out
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         state_reg <= ars_pkg::ARS_IDLE;
         ext_reg   <= 1'b0;
         left_reg  <= 17'h0;
         cur_reg   <= 48'h0;
         done_reg  <= 32'h0;
         wcnt_reg  <= 9'h000;
         fcnt_reg  <= 8'h00;
      end
      else
      begin
         unique case (state_reg)
            ars_pkg::ARS_IDLE:
            begin
               if (op28 || op48)
               begin
                  state_reg <= ars_pkg::ARS_FETCH;
                  ext_reg   <= op48;
                  left_reg  <= op48 ? n48 : n28;
                  cur_reg   <= op48 ? a48 : a28;
                  done_reg  <= 32'h0;
                  fcnt_reg  <= `ARS_FETCH_CYC;
               end
            end
            ars_pkg::ARS_FETCH:
            begin
               // Fixed media latency before words flow
               fcnt_reg <= fcnt_reg - 8'h01;
               if (fcnt_reg == 8'h01)
               begin
                  state_reg <= ars_pkg::ARS_XFER;
                  wcnt_reg  <= 9'h000;
               end
            end
            ars_pkg::ARS_XFER:
            begin
               if (take && fail)
                  state_reg <= ars_pkg::ARS_DONE;
               else if (take)
               begin
                  wcnt_reg <= last_w ? 9'h000 : wcnt_reg + 9'h001;
                  if (finish)
                     state_reg <= ars_pkg::ARS_DONE;
                  else if (sec_end)
                  begin
                     left_reg  <= left_reg - 17'h00001;
                     cur_reg   <= cur_reg + 48'h1;
                     done_reg  <= done_reg + 32'h1;
                     state_reg <= ars_pkg::ARS_FETCH;
                     fcnt_reg  <= `ARS_FETCH_CYC;
                  end
               end
            end
            ars_pkg::ARS_DONE:
               // Hold until the host drains the last word
               if (!word_full_reg)
                  state_reg <= ars_pkg::ARS_IDLE;
            default:
               state_reg <= ars_pkg::ARS_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Transfer word holding stage; host read empties it
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         word_reg      <= 16'h0000;
         word_full_reg <= 1'b0;
      end
      else if (take && !fail)
      begin
         word_reg      <= MEDIA_WORD;
         word_full_reg <= 1'b1;
      end
      else if (pop)
         word_full_reg <= 1'b0;
   end

   // Media request outputs
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         MEDIA_REQ  <= 1'b0;
         MEDIA_ADDR <= 48'h0;
      end
      else
      begin
         MEDIA_REQ  <= state_reg == ars_pkg::ARS_XFER && !word_full_reg
                       && !take;
         MEDIA_ADDR <= cur_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Status and error reporting
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         stat_reg <= `ARS_RESET_STATUS;
         err_reg  <= 8'h00;
      end
      else if (op28 || op48)
      begin
         stat_reg <= 8'h80;
         err_reg  <= 8'h00;
      end
      else if (op_bad)
      begin
         stat_reg <= `ARS_RESET_STATUS | 8'h01;
         err_reg  <= 8'h04;
      end
      else if (state_reg == ars_pkg::ARS_XFER && take && fail)
      begin
         stat_reg <= `ARS_RESET_STATUS | 8'h01 | 8'h08;
         err_reg  <= 8'h40;
      end
      else if (state_reg == ars_pkg::ARS_XFER && finish)
         stat_reg <= `ARS_RESET_STATUS | 8'h08;
      else if (state_reg == ars_pkg::ARS_XFER || state_reg ==
               ars_pkg::ARS_FETCH)
         stat_reg <= word_full_reg ? 8'h58 : 8'h80;
      else if (state_reg == ars_pkg::ARS_DONE && !word_full_reg)
         stat_reg <= stat_reg & 8'hF7;
   end

   // Sticky events, set wins over write-one clear
   wire ev_done = state_reg == ars_pkg::ARS_XFER && finish;
   wire ev_fail = (state_reg == ars_pkg::ARS_XFER && take && fail)
                  || op_bad;
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         irq_stat_reg <= 2'b00;
         IRQ          <= 1'b0;
      end
      else
      begin
         irq_stat_reg <= (irq_stat_reg & ~(wr_ist ? wb[1:0] : 2'b00))
                         | {ev_fail, ev_done};
         IRQ <= |(irq_stat_reg & irq_mask_reg);
      end
   end

endmodule

// ===== sim/ars_assertions.sv
// Bus and media handshake checks for the sector read block.
// Sees only top module ports; bound at the foot of this file.
`timescale 1ns/10ps
`include "ars_map.svh"
module ars_assertions
#(
   parameter int WORDS = 256 // Words per sector
)
(
   // Clock and reset
   input wire logic        CORE_CLK, RST_N,
   // Register bus
   input wire logic        AWVALID, AWREADY, WVALID, WREADY,
   input wire logic [1:0]  BRESP, RRESP,
   input wire logic        BVALID, BREADY, ARVALID, ARREADY,
   input wire logic [11:0] ARADDR,
   input wire logic [31:0] RDATA,
   input wire logic        RVALID, RREADY,
   // Media side and interrupt
   input wire logic        MEDIA_REQ, MEDIA_VALID, IRQ,
   input wire logic [47:0] MEDIA_ADDR
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   ////////////////////////////////////////
   a_word_width: assert property (
      ARVALID && ARREADY && ARADDR == `ARS_OFF_DATA |=> RDATA[31:16] == 0)
      else $error("data word wider than 16 bits");
   a_req_drop: assert property (
      MEDIA_REQ && MEDIA_VALID |=> !MEDIA_REQ)
      else $error("media request stays up with a word held");
   a_addr_hold: assert property (
      MEDIA_REQ && !MEDIA_VALID |=> $stable(MEDIA_ADDR))
      else $error("media address moved while waiting");
   a_rdata_held: assert property (
      RVALID && !RREADY |=> RVALID && $stable(RDATA))
      else $error("read data dropped before accepted");
   a_bresp_held: assert property (
      BVALID && !BREADY |=> BVALID && $stable(BRESP))
      else $error("write response dropped before accepted");
   a_read_answer: assert property (
      ARVALID && ARREADY |=> RVALID)
      else $error("read answer late");
   a_write_answer: assert property (
      AWVALID && AWREADY && WVALID && WREADY |-> ##[1:2] BVALID)
      else $error("write answer late");
   a_refused_zero: assert property (
      RVALID && RRESP == 2'h2 |-> RDATA == 32'h0)
      else $error("refused read carries data");
   a_reset_quiet: assert property (disable iff (1'b0)
      !RST_N |=> !MEDIA_REQ && !IRQ && !RVALID && !BVALID)
      else $error("outputs active after reset");
   // Main scenarios reached
   c_refused: cover property (RVALID && RREADY && RRESP == 2'h2);
   c_media: cover property (MEDIA_REQ && MEDIA_VALID);
   c_irq: cover property ($rose(IRQ));
endmodule

bind ars_read_cmd ars_assertions #(.WORDS(WORDS)) i_chk
(
   .CORE_CLK(CORE_CLK), .RST_N(RST_N), .AWVALID(AWVALID),
   .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
   .RRESP(RRESP), .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID),
   .ARREADY(ARREADY), .ARADDR(ARADDR), .RDATA(RDATA), .RVALID(RVALID),
   .RREADY(RREADY), .MEDIA_REQ(MEDIA_REQ), .MEDIA_VALID(MEDIA_VALID),
   .IRQ(IRQ), .MEDIA_ADDR(MEDIA_ADDR)
);

// ===== sim/ars_media_model.sv
// Media source model: one 16-bit word per request, fast or slow.
// Word is sector address low byte then word index in the sector.
`timescale 1ns/10ps
module ars_media_model
#(
   parameter int WORDS = 4 // Words per sector
)
(
   // Clock and reset
   input wire logic        CORE_CLK,
   input wire logic        RST_N,
   // Pacing from the bench
   input wire logic        SLOW,
   // Media handshake
   input wire logic        MEDIA_REQ,
   input wire logic [47:0] MEDIA_ADDR,
   output logic [15:0]     MEDIA_WORD,
   output logic            MEDIA_VALID
);
   logic [7:0]  idx_reg;  // Word index in sector
   logic [1:0]  gap_reg;  // Stall cycles left
   logic [47:0] addr_reg; // Sector of the last word offered
   // A new sector address restarts the index; a word swallowed by a
   // failing sector would otherwise skew the next command's words
   wire         fresh = MEDIA_ADDR != addr_reg;

   // Hold a word until taken; scramble the bus when idle
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         idx_reg <= 8'h00;
         gap_reg <= 2'h0;
         addr_reg <= 48'hFFFF_FFFF_FFFF;
         MEDIA_VALID <= 1'b0;
         MEDIA_WORD <= 16'hA5A5;
      end
      else if (MEDIA_VALID && MEDIA_REQ) // Taken
      begin
         idx_reg <= (idx_reg == 8'(WORDS - 1)) ? 8'h00 : idx_reg + 8'h01;
         gap_reg <= SLOW ? 2'h3 : 2'h0;
         MEDIA_VALID <= 1'b0;
         MEDIA_WORD <= ~MEDIA_WORD;
      end
      else if (!MEDIA_VALID && MEDIA_REQ && gap_reg == 2'h0)
      begin
         MEDIA_VALID <= 1'b1;
         idx_reg <= fresh ? 8'h00 : idx_reg;
         addr_reg <= MEDIA_ADDR;
         MEDIA_WORD <= {MEDIA_ADDR[7:0], fresh ? 8'h00 : idx_reg};
      end
      else if (!MEDIA_VALID)
      begin
         gap_reg <= (gap_reg == 2'h0) ? 2'h0 : gap_reg - 2'h1;
         MEDIA_WORD <= ~MEDIA_WORD;
      end
   end
endmodule

// ===== sim/tb.sv
// Self-checking bench: AXI4-Lite register tasks and read commands.
// Assumes the media model answers every word request.
`timescale 1ns/10ps
`include "ars_map.svh"
module tb;
   localparam int WD = 4; // Short sectors keep the run brief
   logic        clk = 0, rst_n = 0, slow = 0;
   logic [11:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, rd_d;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
   logic        rready = 0, awready, wready, bvalid, arready, rvalid;
   logic        irq, mreq, mvalid;
   logic [1:0]  bresp, rresp, rd_r;
   logic [47:0] maddr;
   logic [15:0] mword;
   logic [7:0]  ops [3] = '{8'h20, 8'h21, 8'h24};
   int          n_fail = 0, n_checks = 0, cyc = 0;

   always #50 clk = ~clk;

   ars_read_cmd #(.WORDS(WD)) i_dut
   (
      .CORE_CLK(clk), .RST_N(rst_n), .AWADDR(awaddr), .AWVALID(awvalid),
      .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid),
      .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
      .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
      .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
      .MEDIA_REQ(mreq), .MEDIA_ADDR(maddr), .MEDIA_WORD(mword),
      .MEDIA_VALID(mvalid), .IRQ(irq)
   );
   ars_media_model #(.WORDS(WD)) i_media
   (
      .CORE_CLK(clk), .RST_N(rst_n), .SLOW(slow), .MEDIA_REQ(mreq),
      .MEDIA_ADDR(maddr), .MEDIA_WORD(mword), .MEDIA_VALID(mvalid)
   );
   ////////////////////////////////////////
   task stop_test;
      if (n_fail == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Hang guard, sized well above the longest command
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         n_fail++;
         stop_test;
      end
   end

   task chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e)
      begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, s, e);
      end
   endtask

   // Write: address and data offered together, each released when taken
   task wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
   endtask

   task rd(input logic [11:0] a, output logic [31:0] d,
           output logic [1:0] r);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   task rc(input logic [11:0] a, input logic [31:0] e);
      rd(a, rd_d, rd_r);
      chk(rd_d, e);
   endtask

   // Previous value first, then current
   task ld(input logic [11:0] a, input logic [7:0] p, input logic [7:0] c);
      wr(a, {24'h0, p});
      wr(a, {24'h0, c});
   endtask

   // Poll status until a bit of the mask shows
   task poll(input logic [7:0] m);
      do rd(`ARS_OFF_STATUS, rd_d, rd_r);
      while ((rd_d[7:0] & m) == 8'h00);
   endtask

   // Pop n sectors of words; each word names its sector and index
   task drain(input int n, input logic [47:0] base);
      logic [47:0] s;
      for (int i = 0; i < n; i++)
      begin
         s = base + 48'(i);
         for (int w = 0; w < WD; w++)
         begin
            poll(8'h08);
            rc(`ARS_OFF_DATA, {16'h0, s[7:0], 8'(w)});
         end
      end
   endtask
   ////////////////////////////////////////
   initial
   begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      rc(`ARS_OFF_STATUS, 32'h50);
      rd(`ARS_OFF_OPCODE, rd_d, rd_r);
      chk({30'h0, rd_r}, 32'h2);
      // One sector per opcode, slow media on the odd pass
      for (int k = 0; k < 3; k++)
      begin
         slow <= k[0];
         ld(`ARS_OFF_COUNT, 8'h00, 8'h01);
         ld(`ARS_OFF_ADDR_LO, 8'h77, 8'h30 + 8'(k));
         ld(`ARS_OFF_ADDR_MID, 8'h77, 8'h22);
         ld(`ARS_OFF_ADDR_HI, 8'h77, 8'h11);
         wr(`ARS_OFF_TARGET, 32'h45);
         wr(`ARS_OFF_OPCODE, {24'h0, ops[k]});
         drain(1, 48'h30 + 48'(k));
         poll(8'h40);
         rc(`ARS_OFF_STATUS, 32'h50);
         rc(`ARS_OFF_COUNT, 32'h0);
         rc(`ARS_OFF_ADDR_LO, 32'h30 + k);
         rc(`ARS_OFF_TARGET, 32'h45);
      end
      // Masked, then unmasked, then cleared by writing one
      chk({31'h0, irq}, 32'h0);
      wr(`ARS_OFF_IRQ_MASK, 32'h3);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      rc(`ARS_OFF_IRQ_STAT, 32'h1);
      wr(`ARS_OFF_IRQ_STAT, 32'h1);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      // Full 16-bit zero count, third sector fails, low byte carries
      ld(`ARS_OFF_COUNT, 8'h00, 8'h00);
      ld(`ARS_OFF_ADDR_LO, 8'h44, 8'hFF);
      ld(`ARS_OFF_ADDR_MID, 8'h55, 8'h00);
      ld(`ARS_OFF_ADDR_HI, 8'h66, 8'h00);
      wr(`ARS_OFF_INJECT, 32'h80000002);
      wr(`ARS_OFF_OPCODE, 32'h24);
      drain(2, 48'h6655440000FF);
      poll(8'h40);
      wr(`ARS_OFF_INJECT, 32'h0);
      rc(`ARS_OFF_STATUS, 32'h51);
      rc(`ARS_OFF_ERROR, 32'h40);
      rc(`ARS_OFF_COUNT, 32'hFE);
      rc(`ARS_OFF_ADDR_LO, 32'h01);
      rc(`ARS_OFF_ADDR_MID, 32'h01);
      wr(`ARS_OFF_DEVCTL, 32'h80);
      rc(`ARS_OFF_COUNT, 32'hFF);
      rc(`ARS_OFF_ADDR_LO, 32'h44);
      rc(`ARS_OFF_ADDR_HI, 32'h66);
      wr(`ARS_OFF_DEVCTL, 32'h0);
      chk({31'h0, irq}, 32'h1);
      wr(`ARS_OFF_IRQ_STAT, 32'h3);
      // Geometric start, zero count means 256 sectors
      wr(`ARS_OFF_COUNT, 32'h0);
      wr(`ARS_OFF_ADDR_LO, 32'h10);
      wr(`ARS_OFF_ADDR_MID, 32'h0);
      wr(`ARS_OFF_ADDR_HI, 32'h0);
      wr(`ARS_OFF_TARGET, 32'h0);
      wr(`ARS_OFF_OPCODE, 32'h20);
      drain(256, 48'h10);
      poll(8'h40);
      rc(`ARS_OFF_COUNT, 32'h0);
      rc(`ARS_OFF_ADDR_LO, 32'h0F);
      rc(`ARS_OFF_ADDR_MID, 32'h01);
      // Neighbour of the 48-bit opcode is refused
      wr(`ARS_OFF_OPCODE, 32'h25);
      poll(8'h40);
      rc(`ARS_OFF_STATUS, 32'h51);
      rc(`ARS_OFF_ERROR, 32'h04);
      stop_test;
   end
endmodule
